// ---- core/cte_cfg.svh ----
// constants for the ccm task and event control block
// Function
// [RULE1] key-stream task starts generation, self-terminating
// [RULE2] crypt task starts crypt, self-terminating
// [RULE3] halt task stops running crypt operation
// [RULE4] speed task substitutes override rate into mode
// [RULE5] key-stream done flag set on completion
// [RULE6] crypt done flag set on completion
// [RULE7] one-bit deprecated fault flag readable
// [RULE8] long-frame length sets generated key-stream
// [RULE9] override rate register holds substitute rate
// [RULE10] memory accesses finished before done events
// [RULE11] interrupt set register enables, zero ignored
// [RULE12] software clears flag by writing zero
`ifndef CTE_CFG_SVH
`define CTE_CFG_SVH
`define CTE_OFF_KS_TASK 12'h000
`define CTE_OFF_CRYPT_TASK 12'h004
`define CTE_OFF_HALT_TASK 12'h008
`define CTE_OFF_SPEED_TASK 12'h00c
`define CTE_OFF_KS_EVENT 12'h100
`define CTE_OFF_CRYPT_EVENT 12'h104
`define CTE_OFF_FAULT_EVENT 12'h108
`define CTE_OFF_INT_SET 12'h304
`define CTE_OFF_INT_CLR 12'h308
`define CTE_OFF_LONG_LEN 12'h518
`define CTE_OFF_OVR_SPEED 12'h51c
`define CTE_OFF_MODE_CTRL 12'h520
`define CTE_OFF_INT_STATUS 12'h524
`define CTE_BIT_TRIGGER 0
`define CTE_BIT_FLAG 0
`define CTE_BIT_INT_KS 0
`define CTE_BIT_INT_CRYPT 1
`define CTE_BIT_INT_FAULT 2
`define CTE_BIT_MODE_LONG 0
`define CTE_BIT_MODE_SPEED_LO 4
`define CTE_RST_LONG_LEN 32'h0000_0000
`define CTE_RST_OVR_SPEED 32'h0000_0000
`define CTE_RST_MODE 32'h0000_0000
`define CTE_RST_WORD 32'h0000_0000
`define CTE_SHORT_KS_LEN 32'h0000_001b
`define CTE_INT_W 3
`define CTE_ZERO_INT 3'h0
`endif

// ---- core/cte_pkg.sv ----
// types for the ccm task and event control block
package cte_pkg;
  typedef enum logic [1:0] {
    CTE_IDLE = 2'b00,
    CTE_RUN = 2'b01,
    CTE_DRAIN = 2'b11
  } cte_op_state_type;

  typedef struct packed {
    logic ks_fin;
    logic crypt_fin;
    logic mem_idle;
    logic fault;
  } cte_dp_in_type;

  typedef struct packed {
    logic ks_run;
    logic crypt_run;
    logic [31:0] ks_len;
    logic [3:0] speed;
  } cte_dp_out_type;
endpackage : cte_pkg

// ---- core/cte_top.sv ----
// ccm task and event control with apb register slave
`timescale 1ns/1ps
`include "cte_cfg.svh"
module cte_top #(
  parameter int SPEED_W = 4
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input cte_pkg::cte_dp_in_type DP_IN,
  output cte_pkg::cte_dp_out_type DP_OUT,
  output logic IRQ
);
  import cte_pkg::*;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `CTE_OFF_KS_TASK) || hit(a, `CTE_OFF_CRYPT_TASK) || hit(a, `CTE_OFF_HALT_TASK)
      || hit(a, `CTE_OFF_SPEED_TASK) || hit(a, `CTE_OFF_KS_EVENT) || hit(a, `CTE_OFF_CRYPT_EVENT)
      || hit(a, `CTE_OFF_FAULT_EVENT) || hit(a, `CTE_OFF_INT_SET) || hit(a, `CTE_OFF_INT_CLR)
      || hit(a, `CTE_OFF_LONG_LEN) || hit(a, `CTE_OFF_OVR_SPEED) || hit(a, `CTE_OFF_MODE_CTRL)
      || hit(a, `CTE_OFF_INT_STATUS);
  endfunction : mapped

  logic setup_ph;
  logic wr_acc;
  logic trig;
  logic ks_go;
  logic crypt_go;
  logic halt_go;
  logic speed_go;
  logic ks_fin_r;
  logic crypt_fin_r;
  cte_op_state_type ks_state_r;
  cte_op_state_type crypt_state_r;
  logic ev_ks_r;
  logic ev_crypt_r;
  logic ev_fault_r;
  logic [`CTE_INT_W-1:0] int_en_r;
  logic [`CTE_INT_W-1:0] ev_vec;
  logic [31:0] long_len_r;
  logic [31:0] ovr_speed_r;
  logic [31:0] mode_r;
  logic speed_sub_r;
  logic [31:0] prdata_nxt;
  cte_dp_out_type dp_out_nxt;

  // apb decode: zero wait states, error on unmapped address
  assign setup_ph = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE && mapped(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
  assign trig = wr_acc && PWDATA[`CTE_BIT_TRIGGER];
  assign ks_go = trig && hit(PADDR, `CTE_OFF_KS_TASK);
  assign crypt_go = trig && hit(PADDR, `CTE_OFF_CRYPT_TASK);
  assign halt_go = trig && hit(PADDR, `CTE_OFF_HALT_TASK);
  assign speed_go = trig && hit(PADDR, `CTE_OFF_SPEED_TASK);
  assign ev_vec = {ev_fault_r, ev_crypt_r, ev_ks_r};

  // key-stream operation runs until the datapath finishes and memory drains
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ks_state_r <= CTE_IDLE;
    end else begin
      case (ks_state_r)
        CTE_IDLE: begin
          if (ks_go) begin
            ks_state_r <= CTE_RUN; // [RULE1]
          end
        end
        CTE_RUN: begin
          if (DP_IN.ks_fin) begin
            ks_state_r <= CTE_DRAIN; // [RULE1]
          end
        end
        CTE_DRAIN: begin
          if (DP_IN.mem_idle) begin
            ks_state_r <= CTE_IDLE; // [RULE10]
          end
        end
        default: ks_state_r <= CTE_IDLE;
      endcase
    end
  end

  // crypt operation; halt aborts it without a done event
  always_ff @(posedge CLK) begin
    if (RESET) begin
      crypt_state_r <= CTE_IDLE;
    end else begin
      case (crypt_state_r)
        CTE_IDLE: begin
          if (crypt_go) begin
            crypt_state_r <= CTE_RUN; // [RULE2]
          end
        end
        CTE_RUN: begin
          if (halt_go) begin
            crypt_state_r <= CTE_IDLE; // [RULE3]
          end else if (DP_IN.crypt_fin) begin
            crypt_state_r <= CTE_DRAIN; // [RULE2]
          end
        end
        CTE_DRAIN: begin
          if (halt_go) begin
            crypt_state_r <= CTE_IDLE; // [RULE3]
          end else if (DP_IN.mem_idle) begin
            crypt_state_r <= CTE_IDLE; // [RULE10]
          end
        end
        default: crypt_state_r <= CTE_IDLE;
      endcase
    end
  end

  // completion strobes, raised only once memory is idle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ks_fin_r <= 1'b0;
      crypt_fin_r <= 1'b0;
    end else begin
      ks_fin_r <= (ks_state_r == CTE_DRAIN) && DP_IN.mem_idle; // [RULE10]
      crypt_fin_r <= (crypt_state_r == CTE_DRAIN) && DP_IN.mem_idle && !halt_go; // [RULE10]
    end
  end

  // event flags: hardware set wins over a software write of zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ev_ks_r <= 1'b0;
      ev_crypt_r <= 1'b0;
      ev_fault_r <= 1'b0;
    end else begin
      if (ks_fin_r) begin
        ev_ks_r <= 1'b1; // [RULE5]
      end else if (wr_acc && hit(PADDR, `CTE_OFF_KS_EVENT)) begin
        ev_ks_r <= PWDATA[`CTE_BIT_FLAG]; // [RULE12]
      end
      if (crypt_fin_r) begin
        ev_crypt_r <= 1'b1; // [RULE6]
      end else if (wr_acc && hit(PADDR, `CTE_OFF_CRYPT_EVENT)) begin
        ev_crypt_r <= PWDATA[`CTE_BIT_FLAG]; // [RULE12]
      end
      if (DP_IN.fault) begin
        ev_fault_r <= 1'b1; // [RULE7]
      end else if (wr_acc && hit(PADDR, `CTE_OFF_FAULT_EVENT)) begin
        ev_fault_r <= PWDATA[`CTE_BIT_FLAG]; // [RULE12]
      end
    end
  end

  // interrupt enables: write-one-to-set and write-one-to-clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      int_en_r <= `CTE_ZERO_INT;
    end else if (wr_acc && hit(PADDR, `CTE_OFF_INT_SET)) begin
      int_en_r <= int_en_r | PWDATA[`CTE_INT_W-1:0]; // [RULE11]
    end else if (wr_acc && hit(PADDR, `CTE_OFF_INT_CLR)) begin
      int_en_r <= int_en_r & ~PWDATA[`CTE_INT_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(ev_vec & int_en_r);
    end
  end

  // configuration registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      long_len_r <= `CTE_RST_LONG_LEN;
      ovr_speed_r <= `CTE_RST_OVR_SPEED;
      mode_r <= `CTE_RST_MODE;
    end else if (wr_acc) begin
      if (hit(PADDR, `CTE_OFF_LONG_LEN)) begin
        long_len_r <= PWDATA; // [RULE8]
      end
      if (hit(PADDR, `CTE_OFF_OVR_SPEED)) begin
        ovr_speed_r <= PWDATA; // [RULE9]
      end
      if (hit(PADDR, `CTE_OFF_MODE_CTRL)) begin
        mode_r <= PWDATA;
      end
    end
  end

  // rate substitution lasts for the running crypt operation only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      speed_sub_r <= 1'b0;
    end else if (crypt_state_r == CTE_IDLE) begin
      speed_sub_r <= 1'b0;
    end else if (speed_go) begin
      speed_sub_r <= 1'b1; // [RULE4]
    end
  end

  // datapath control outputs
  always_comb begin
    dp_out_nxt.ks_run = (ks_state_r == CTE_RUN);
    dp_out_nxt.crypt_run = (crypt_state_r == CTE_RUN);
    dp_out_nxt.ks_len = mode_r[`CTE_BIT_MODE_LONG] ? long_len_r : `CTE_SHORT_KS_LEN; // [RULE8]
    dp_out_nxt.speed = speed_sub_r ? ovr_speed_r[SPEED_W-1:0] // [RULE4]
      : mode_r[`CTE_BIT_MODE_SPEED_LO +: SPEED_W];
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      DP_OUT <= '0;
    end else begin
      DP_OUT <= dp_out_nxt;
    end
  end

  // read mux; task registers read as zero
  always_comb begin
    prdata_nxt = `CTE_RST_WORD;
    case (PADDR)
      `CTE_OFF_KS_EVENT: prdata_nxt[`CTE_BIT_FLAG] = ev_ks_r; // [RULE5]
      `CTE_OFF_CRYPT_EVENT: prdata_nxt[`CTE_BIT_FLAG] = ev_crypt_r; // [RULE6]
      `CTE_OFF_FAULT_EVENT: prdata_nxt[`CTE_BIT_FLAG] = ev_fault_r; // [RULE7]
      `CTE_OFF_INT_SET: prdata_nxt[`CTE_INT_W-1:0] = int_en_r;
      `CTE_OFF_INT_CLR: prdata_nxt[`CTE_INT_W-1:0] = int_en_r;
      `CTE_OFF_LONG_LEN: prdata_nxt = long_len_r;
      `CTE_OFF_OVR_SPEED: prdata_nxt = ovr_speed_r;
      `CTE_OFF_MODE_CTRL: prdata_nxt = mode_r;
      `CTE_OFF_INT_STATUS: prdata_nxt[`CTE_INT_W-1:0] = ev_vec;
      default: prdata_nxt = `CTE_RST_WORD;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= `CTE_RST_WORD;
    end else if (setup_ph && !PWRITE) begin
      PRDATA <= prdata_nxt;
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_ks_start_run: assert property (ks_go && ks_state_r == CTE_IDLE |=> ks_state_r == CTE_RUN) // [RULE1]
    else $error("key-stream task did not start generation");
  a_crypt_start_run: assert property (crypt_go && crypt_state_r == CTE_IDLE |=> crypt_state_r == CTE_RUN) // [RULE2]
    else $error("crypt task did not start operation");
  a_halt_stops_crypt: assert property (halt_go && crypt_state_r != CTE_IDLE |=> crypt_state_r == CTE_IDLE ##1 !crypt_fin_r) // [RULE3]
    else $error("halt did not stop crypt without done event");
  a_speed_substitute: assert property (speed_go && crypt_state_r == CTE_RUN && !halt_go && !DP_IN.crypt_fin
    |=> ##1 DP_OUT.speed == $past(ovr_speed_r[SPEED_W-1:0])) // [RULE4]
    else $error("override rate not applied to running crypt");
  a_ks_done_flag: assert property (ks_state_r == CTE_DRAIN && DP_IN.mem_idle |=> ##1 ev_ks_r) // [RULE5]
    else $error("key-stream done flag not set");
  a_crypt_done_flag: assert property ($rose(ev_crypt_r) |-> $past(crypt_fin_r)
    || $past(wr_acc && hit(PADDR, `CTE_OFF_CRYPT_EVENT))) // [RULE6]
    else $error("crypt done flag rose without cause");
  a_fault_flag: assert property (DP_IN.fault |=> ev_fault_r) // [RULE7]
    else $error("fault flag not set");
  a_long_len: assert property (mode_r[`CTE_BIT_MODE_LONG] |=> DP_OUT.ks_len == $past(long_len_r)) // [RULE8]
    else $error("long-frame length not used");
  a_ovr_store: assert property (wr_acc && hit(PADDR, `CTE_OFF_OVR_SPEED) |=> ovr_speed_r == $past(PWDATA)) // [RULE9]
    else $error("override rate not stored");
  a_mem_before_done: assert property ($rose(ev_ks_r) && !$past(wr_acc) |-> $past(DP_IN.mem_idle, 2)) // [RULE10]
    else $error("key-stream done raised before memory idle");
  a_int_set_only: assert property (wr_acc && hit(PADDR, `CTE_OFF_INT_SET) |=> (int_en_r & $past(int_en_r))
    == $past(int_en_r)) // [RULE11]
    else $error("interrupt set register cleared an enable");
  a_flag_sticky: assert property (ev_ks_r && !(wr_acc && hit(PADDR, `CTE_OFF_KS_EVENT)) |=> ev_ks_r) // [RULE12]
    else $error("key-stream flag dropped without software clear");
  a_irq_level: assert property (|(ev_vec & int_en_r) |=> IRQ)
    else $error("interrupt not raised for enabled event");
  a_irq_low: assert property (!(|(ev_vec & int_en_r)) |=> !IRQ)
    else $error("interrupt raised with no enabled event");
  // sequencing and register effects
  a_ks_self_end: assert property (ks_state_r == CTE_DRAIN && DP_IN.mem_idle |=> ks_state_r == CTE_IDLE) // [RULE1]
    else $error("key-stream operation did not end by itself");
  a_ks_run_out: assert property (ks_state_r == CTE_RUN |=> DP_OUT.ks_run) // [RULE1]
    else $error("key-stream run output missing");
  a_crypt_self_end: assert property (crypt_state_r == CTE_DRAIN && DP_IN.mem_idle // [RULE2]
    |=> crypt_state_r == CTE_IDLE)
    else $error("crypt operation did not end by itself");
  a_crypt_run_out: assert property (crypt_state_r == CTE_RUN |=> DP_OUT.crypt_run) // [RULE2]
    else $error("crypt run output missing");
  a_halt_no_done: assert property (halt_go |=> !crypt_fin_r) // [RULE3]
    else $error("halt let a crypt done strobe through");
  a_halt_idle_ignored: assert property (halt_go && crypt_state_r == CTE_IDLE // [RULE3]
    |=> crypt_state_r == CTE_IDLE)
    else $error("halt while idle started an operation");
  a_speed_ends_idle: assert property (crypt_state_r == CTE_IDLE |=> !speed_sub_r) // [RULE4]
    else $error("rate substitution outlived the crypt operation");
  a_speed_from_mode: assert property (!speed_sub_r // [RULE4]
    |=> DP_OUT.speed == $past(mode_r[`CTE_BIT_MODE_SPEED_LO +: SPEED_W]))
    else $error("mode rate not used without substitution");
  a_ks_flag_set: assert property (ks_fin_r |=> ev_ks_r) // [RULE5]
    else $error("key-stream done strobe did not set flag");
  a_crypt_flag_set: assert property (crypt_fin_r |=> ev_crypt_r) // [RULE6]
    else $error("crypt done strobe did not set flag");
  a_fault_sticky: assert property (ev_fault_r && !(wr_acc && hit(PADDR, `CTE_OFF_FAULT_EVENT)) // [RULE7]
    |=> ev_fault_r)
    else $error("fault flag dropped without software clear");
  a_fault_read: assert property (PSEL && !PENABLE && !PWRITE && hit(PADDR, `CTE_OFF_FAULT_EVENT) // [RULE7]
    |=> PRDATA[`CTE_BIT_FLAG] == $past(ev_fault_r))
    else $error("fault flag read back wrong");
  a_short_len: assert property (!mode_r[`CTE_BIT_MODE_LONG] |=> DP_OUT.ks_len == `CTE_SHORT_KS_LEN) // [RULE8]
    else $error("short key-stream length not used");
  a_long_store: assert property (wr_acc && hit(PADDR, `CTE_OFF_LONG_LEN) |=> long_len_r == $past(PWDATA)) // [RULE8]
    else $error("long-frame length not stored");
  a_ovr_read: assert property (PSEL && !PENABLE && !PWRITE && hit(PADDR, `CTE_OFF_OVR_SPEED) // [RULE9]
    |=> PRDATA == $past(ovr_speed_r))
    else $error("override rate read back wrong");
  a_crypt_mem_done: assert property ($rose(ev_crypt_r) && !$past(wr_acc) |-> $past(DP_IN.mem_idle, 2)) // [RULE10]
    else $error("crypt done raised before memory idle");
  a_int_set_value: assert property (wr_acc && hit(PADDR, `CTE_OFF_INT_SET) // [RULE11]
    |=> int_en_r == ($past(int_en_r) | $past(PWDATA[`CTE_INT_W-1:0])))
    else $error("interrupt set register gave wrong enables");
  a_int_clr_value: assert property (wr_acc && hit(PADDR, `CTE_OFF_INT_CLR)
    |=> int_en_r == ($past(int_en_r) & ~$past(PWDATA[`CTE_INT_W-1:0])))
    else $error("interrupt clear register gave wrong enables");
  a_flag_clear: assert property (ev_crypt_r && !crypt_fin_r && wr_acc && hit(PADDR, `CTE_OFF_CRYPT_EVENT) // [RULE12]
    && !PWDATA[`CTE_BIT_FLAG] |=> !ev_crypt_r)
    else $error("crypt flag not cleared by software write");
  a_task_reads_zero: assert property (PSEL && !PENABLE && !PWRITE && hit(PADDR, `CTE_OFF_KS_TASK)
    |=> PRDATA == `CTE_RST_WORD)
    else $error("task register did not read zero");

  c_ks_done: cover property (ks_go ##[1:20] $rose(ev_ks_r));
  c_crypt_done: cover property (crypt_go ##[1:20] $rose(ev_crypt_r));
  c_halt: cover property (crypt_state_r == CTE_RUN && halt_go);
  c_override: cover property (speed_go && crypt_state_r == CTE_RUN);
  c_int_fire: cover property ($rose(IRQ));
endmodule : cte_top

// ---- tb/cte_top_bench.sv ----
// self-checking bench for the ccm task and event control block
`timescale 1ns/1ps
`include "cte_cfg.svh"
module cte_top_bench;
  import cte_pkg::*;
  typedef struct {logic rd; logic err; logic [31:0] d;} cte_note_type;
  localparam int KS_FIN = 3;
  localparam int CRYPT_FIN = 2;
  localparam int FAULT = 0;
  localparam logic [11:0] RST_TAB [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h100, 12'h104, 12'h108,
    12'h304, 12'h524};
  logic clk, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, len_v, ovr_v;
  cte_dp_in_type dp_in;
  cte_dp_out_type dp_out;
  cte_note_type notes[$];
  int fails, samples_checked;

  cte_top i_cte_top (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DP_IN(dp_in), .DP_OUT(dp_out),
    .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err,
    input logic [31:0] e);
    notes.push_back('{!w, err, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 1'b0, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task pulse(input int k);
    @(posedge clk);
    dp_in[k] <= 1'b1;
    @(posedge clk);
    dp_in[k] <= 1'b0;
  endtask : pulse

  // read and error results are compared against the oldest note
  always @(posedge clk) begin
    cte_note_type n;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("[ERR] %0t transfer without a note", $time);
      end else begin
        n = notes.pop_front();
        check({31'h0, pslverr}, {31'h0, n.err});
        if (n.rd) check(prdata, n.d);
      end
    end
  end

  initial begin
    #100000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dp_in = 4'b0010;
    fails = 0;
    samples_checked = 0;
    seed = 32'h0000_3bc0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    idle(1);
    check({31'h0, irq}, 32'h0000_0000);
    check({30'h0, dp_out.ks_run, dp_out.crypt_run}, 32'h0000_0000);
    foreach (RST_TAB[i]) rd(RST_TAB[i], 32'h0000_0000);
    len_v = xs();
    ovr_v = (xs() & 32'hffff_fff0) | 32'h0000_000a;
    wr(`CTE_OFF_LONG_LEN, len_v);
    rd(`CTE_OFF_LONG_LEN, len_v);
    wr(`CTE_OFF_OVR_SPEED, ovr_v);
    rd(`CTE_OFF_OVR_SPEED, ovr_v);
    apb(1'b1, 12'h200, xs(), 1'b1, 32'h0000_0000);
    apb(1'b0, 12'h200, 32'h0000_0000, 1'b1, 32'h0000_0000);
    apb(1'b1, 12'hffc, xs(), 1'b1, 32'h0000_0000);
    // long-frame select picks the programmed length, otherwise the short one
    wr(`CTE_OFF_MODE_CTRL, 32'h0000_0001);
    idle(3);
    check(dp_out.ks_len, len_v);
    wr(`CTE_OFF_MODE_CTRL, 32'h0000_0050);
    idle(3);
    check(dp_out.ks_len, `CTE_SHORT_KS_LEN);
    // key-stream run, done held back while memory is busy
    wr(`CTE_OFF_KS_TASK, 32'h0000_0001);
    idle(3);
    check({31'h0, dp_out.ks_run}, 32'h0000_0001);
    @(posedge clk);
    dp_in.mem_idle <= 1'b0;
    pulse(KS_FIN);
    idle(4);
    rd(`CTE_OFF_KS_EVENT, 32'h0000_0000);
    @(posedge clk);
    dp_in.mem_idle <= 1'b1;
    idle(4);
    rd(`CTE_OFF_KS_EVENT, 32'h0000_0001);
    check({31'h0, dp_out.ks_run}, 32'h0000_0000);
    // crypt run with speed substitution
    wr(`CTE_OFF_CRYPT_TASK, 32'h0000_0001);
    idle(3);
    check({31'h0, dp_out.crypt_run}, 32'h0000_0001);
    check({28'h0, dp_out.speed}, 32'h0000_0005);
    wr(`CTE_OFF_SPEED_TASK, 32'h0000_0001);
    idle(3);
    check({28'h0, dp_out.speed}, {28'h0, ovr_v[3:0]});
    pulse(CRYPT_FIN);
    idle(4);
    rd(`CTE_OFF_CRYPT_EVENT, 32'h0000_0001);
    check({31'h0, dp_out.crypt_run}, 32'h0000_0000);
    check({28'h0, dp_out.speed}, 32'h0000_0005);
    wr(`CTE_OFF_SPEED_TASK, 32'h0000_0001);
    idle(3);
    check({28'h0, dp_out.speed}, 32'h0000_0005);
    // halt in mid-run gives no done event
    wr(`CTE_OFF_CRYPT_EVENT, 32'h0000_0000);
    rd(`CTE_OFF_CRYPT_EVENT, 32'h0000_0000);
    wr(`CTE_OFF_CRYPT_TASK, 32'h0000_0001);
    idle(3);
    wr(`CTE_OFF_HALT_TASK, 32'h0000_0001);
    idle(4);
    check({31'h0, dp_out.crypt_run}, 32'h0000_0000);
    rd(`CTE_OFF_CRYPT_EVENT, 32'h0000_0000);
    // fault flag and interrupt enables
    check({31'h0, irq}, 32'h0000_0000);
    pulse(FAULT);
    idle(3);
    rd(`CTE_OFF_FAULT_EVENT, 32'h0000_0001);
    wr(`CTE_OFF_INT_SET, 32'h0000_0001);
    idle(3);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`CTE_OFF_INT_SET, 32'h0000_0000);
    rd(`CTE_OFF_INT_SET, 32'h0000_0001);
    wr(`CTE_OFF_INT_CLR, 32'h0000_0001);
    idle(3);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`CTE_OFF_INT_SET, 32'h0000_0004);
    rd(`CTE_OFF_INT_SET, 32'h0000_0004);
    idle(2);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`CTE_OFF_FAULT_EVENT, 32'h0000_0000);
    idle(3);
    check({31'h0, irq}, 32'h0000_0000);
    rd(`CTE_OFF_FAULT_EVENT, 32'h0000_0000);
    idle(2);
    finish_test();
  end
endmodule : cte_top_bench
